// ### verilog/trap_and_vector_dispatch.sv
// trap, software trap and interrupt vector dispatch with register port
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module trap_and_vector_dispatch
    import trap_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   irq_o,
    input  wire logic              sw_reset_i,
    input  wire logic              wdt_overflow_i,
    input  wire logic              nmi_n_i,
    input  wire logic              stack_overrun_i,
    input  wire logic              stack_underrun_i,
    input  wire logic              unknown_opcode_i,
    input  wire logic              protected_fault_i,
    input  wire logic              misaligned_operand_i,
    input  wire logic              bad_fetch_i,
    input  wire logic              bad_bus_i,
    input  wire logic              sw_trap_i,
    input  wire logic [6:0]        sw_trap_num_i,
    input  wire logic [NUM_SRC-1:0] src_event_i,
    input  wire logic              pec_req_i,
    output logic                   pec_grant_o,
    output logic                   vector_valid_o,
    output logic [VEC_W-1:0]       vector_addr_o,
    output logic [TN_W-1:0]        trap_num_o,
    input  wire logic              vector_ack_i,
    input  wire logic              service_done_i,
    output logic                   in_trap_o,
    output logic [LVL_W-1:0]       cpu_level_o
);
    // ****************************************
    // declarations
    // ****************************************
    logic                   rst_s1_ff;
    logic                   rst_n;
    logic                   nmi_lvl;
    logic                   nmi_prev_ff;
    logic                   nmi_evt;
    logic [FLAG_W-1:0]      ev;
    logic [FLAG_W-1:0]      flags_ff;
    logic [FLAG_W-1:0]      pend_ff;
    logic [FLAG_W-1:0]      clr_pend;
    logic                   reset_pend_ff;
    logic                   sw_pend_ff;
    logic [6:0]             sw_num_ff;
    logic [EV_W-1:0]        status_ff;
    logic [EV_W-1:0]        mask_ff;
    logic [EV_W-1:0]        evs;
    logic [CTRL_W-1:0]      ctrl_ff [NUM_SRC];
    logic [NUM_SRC-1:0]     act;
    logic [NUM_SRC*LVL_W-1:0] prio_flat;
    logic                   win_vld;
    logic [IDX_W-1:0]       win_idx;
    logic [LVL_W-1:0]       win_prio;
    state_t                 state_ff;
    kind_t                  sel_kind;
    logic [TN_W-1:0]        sel_tn;
    logic [VEC_W-1:0]       sel_vec;
    logic [TLVL_W-1:0]      sel_tlvl;
    logic [LVL_W-1:0]       sel_clvl;
    logic [TLVL_W-1:0]      trap_lvl_ff;
    logic [SP_W-1:0]        sp_ff;
    logic [TLVL_W+LVL_W-1:0] stk_ff [STACK_D];
    logic                   accept;

    function automatic logic src_hit(input logic [ADDR_W-1:0] a);
        src_hit = (a >= OFF_SRC_BASE) && (a < OFF_SRC_END) && (a[1:0] == 2'h0);
    endfunction : src_hit

    function automatic logic [IDX_W-1:0] src_idx(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d       = a - OFF_SRC_BASE;
        src_idx = d[IDX_W+1:2];
    endfunction : src_idx

    // ****************************************
    // reset release and pin input
    // ****************************************
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1_ff <= 1'b0;
            rst_n     <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n     <= rst_s1_ff;
        end
    end

    pin_sync #(
        .RST_VAL (1'b1)
    ) u_nmi_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .pin_i   (nmi_n_i),
        .lvl_o   (nmi_lvl)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nmi_prev_ff <= 1'b1;
        end else begin
            nmi_prev_ff <= nmi_lvl;
        end
    end

    // nmi fires on the falling edge of the filtered pin
    assign nmi_evt        = nmi_prev_ff & ~nmi_lvl;
    assign ev[F_NMI]      = nmi_evt;
    assign ev[F_STACK_OVERRUN_FLAG]    = stack_overrun_i;
    assign ev[F_STACK_UNDERRUN_FLAG]    = stack_underrun_i;
    assign ev[F_UNK]      = unknown_opcode_i;
    assign ev[F_PROT]     = protected_fault_i;
    assign ev[F_MIS]      = misaligned_operand_i;
    assign ev[F_FETCH]    = bad_fetch_i;
    assign ev[F_BUS]      = bad_bus_i;

    // ****************************************
    // exception flags and pending traps
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= RST_FLAGS;
        end else if (wr_i && addr_i == OFF_FLAGS) begin
            flags_ff <= (flags_ff & ~wdata_i[FLAG_W-1:0]) | ev;
        end else begin
            flags_ff <= flags_ff | ev;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_ff <= RST_FLAGS;
        end else if (sel_kind == K_RESET) begin
            pend_ff <= ev;
        end else begin
            pend_ff <= (pend_ff & ~clr_pend) | ev;
        end
    end

    // hardware reset leaves a reset dispatch pending
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reset_pend_ff <= 1'b1;
        end else if (sw_reset_i || wdt_overflow_i) begin
            reset_pend_ff <= 1'b1;
        end else if (sel_kind == K_RESET) begin
            reset_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sw_pend_ff <= 1'b0;
            sw_num_ff  <= 7'h00;
        end else if (sw_trap_i && (!sw_pend_ff || sel_kind == K_SW)) begin
            sw_pend_ff <= 1'b1;
            sw_num_ff  <= sw_trap_num_i;
        end else if (sel_kind == K_SW || sel_kind == K_RESET) begin
            sw_pend_ff <= 1'b0;
        end
    end

    // ****************************************
    // interrupt source control registers
    // ****************************************
    generate
        for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
            always_ff @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_ff[g] <= RST_CTRL;
                end else begin
                    if (wr_i && src_hit(addr_i) && src_idx(addr_i) == IDX_W'(g)) begin
                        ctrl_ff[g] <= wdata_i[CTRL_W-1:0];
                    end else if (sel_kind == K_INT && win_idx == IDX_W'(g)) begin
                        ctrl_ff[g][C_REQ] <= 1'b0;
                    end
                    if (src_event_i[g]) begin
                        ctrl_ff[g][C_REQ] <= 1'b1;
                    end
                end
            end
            assign act[g] = ctrl_ff[g][C_REQ] & ctrl_ff[g][C_EN];
            assign prio_flat[g*LVL_W +: LVL_W] = ctrl_ff[g][LVL_W-1:0];
        end
    endgenerate

    irq_arbiter u_arb (
        .act_i      (act),
        .prio_i     (prio_flat),
        .win_vld_o  (win_vld),
        .win_idx_o  (win_idx),
        .win_prio_o (win_prio)
    );

    // ****************************************
    // dispatch selection
    // ****************************************
    always_comb begin
        sel_kind = K_NONE;
        sel_tn   = TN_RESET;
        sel_vec  = RESET_VECTOR;
        sel_tlvl = trap_lvl_ff;
        sel_clvl = cpu_level_o;
        clr_pend = '0;
        if (state_ff == ST_IDLE && !service_done_i) begin
            if (reset_pend_ff) begin
                sel_kind = K_RESET;
                sel_tlvl = TPRI_NONE;
                sel_clvl = RST_LVL;
            end else if (pend_ff[F_NMI] && TPRI_A > trap_lvl_ff) begin
                sel_kind = K_TRAP_A;
                sel_tn   = TN_NMI;
                sel_vec  = NONMASKABLE_VECTOR;
                sel_tlvl = TPRI_A;
                clr_pend[F_NMI] = 1'b1;
            end else if (pend_ff[F_STACK_OVERRUN_FLAG] && TPRI_A > trap_lvl_ff) begin
                sel_kind = K_TRAP_A;
                sel_tn   = TN_STACK_OVERRUN_FLAG;
                sel_vec  = STACK_OVERRUN_VECTOR;
                sel_tlvl = TPRI_A;
                clr_pend[F_STACK_OVERRUN_FLAG] = 1'b1;
            end else if (pend_ff[F_STACK_UNDERRUN_FLAG] && TPRI_A > trap_lvl_ff) begin
                sel_kind = K_TRAP_A;
                sel_tn   = TN_STACK_UNDERRUN_FLAG;
                sel_vec  = STACK_UNDERRUN_VECTOR;
                sel_tlvl = TPRI_A;
                clr_pend[F_STACK_UNDERRUN_FLAG] = 1'b1;
            end else if ((|pend_ff[F_BUS:F_UNK]) && TPRI_B > trap_lvl_ff) begin
                sel_kind = K_TRAP_B;
                sel_tn   = TN_CLASS_B;
                sel_vec  = CLASS_B_SHARED_VECTOR;
                sel_tlvl = TPRI_B;
                clr_pend[F_BUS:F_UNK] = 5'h1F;
            end else if (sw_pend_ff) begin
                sel_kind = K_SW;
                sel_tn   = {1'b0, sw_num_ff};
                sel_vec  = vec_of(sel_tn);
            end else if (win_vld && trap_lvl_ff == TPRI_NONE
                         && win_prio > cpu_level_o) begin
                sel_kind = K_INT;
                sel_tn   = TN_SRC_BASE + TN_W'(win_idx);
                sel_vec  = vec_of(sel_tn);
                sel_clvl = win_prio;
            end
        end
    end

    assign accept = (sel_kind != K_NONE);

    // ****************************************
    // vector offer to the core
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_ff       <= ST_IDLE;
            vector_valid_o <= 1'b0;
            vector_addr_o  <= RESET_VECTOR;
            trap_num_o     <= TN_RESET;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (accept) begin
                        state_ff       <= ST_OFFER;
                        vector_valid_o <= 1'b1;
                        vector_addr_o  <= sel_vec;
                        trap_num_o     <= sel_tn;
                    end
                end
                ST_OFFER: begin
                    if (vector_ack_i) begin
                        state_ff       <= ST_IDLE;
                        vector_valid_o <= 1'b0;
                    end
                end
                default: begin
                    state_ff       <= ST_IDLE;
                    vector_valid_o <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // service level stack
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sp_ff       <= '0;
            trap_lvl_ff <= TPRI_NONE;
            cpu_level_o <= RST_LVL;
        end else if (sel_kind == K_RESET) begin
            sp_ff       <= '0;
            trap_lvl_ff <= TPRI_NONE;
            cpu_level_o <= RST_LVL;
        end else if (accept) begin
            if (sp_ff < SP_W'(STACK_D)) begin
                stk_ff[sp_ff[SPI_W-1:0]] <= {trap_lvl_ff, cpu_level_o};
                sp_ff                    <= sp_ff + SP_W'(1);
            end
            trap_lvl_ff <= sel_tlvl;
            cpu_level_o <= sel_clvl;
        end else if (service_done_i && sp_ff != '0) begin
            {trap_lvl_ff, cpu_level_o} <= stk_ff[SPI_W'(sp_ff - SP_W'(1))];
            sp_ff                      <= sp_ff - SP_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            in_trap_o   <= 1'b0;
            pec_grant_o <= 1'b0;
        end else begin
            in_trap_o   <= (trap_lvl_ff != TPRI_NONE);
            pec_grant_o <= pec_req_i && trap_lvl_ff == TPRI_NONE;
        end
    end

    // ****************************************
    // event status, mask and interrupt
    // ****************************************
    assign evs[EV_TRAP] = (sel_kind == K_TRAP_A) || (sel_kind == K_TRAP_B);
    assign evs[EV_INT]  = (sel_kind == K_INT);
    assign evs[EV_SW]   = (sel_kind == K_SW);
    assign evs[EV_RST]  = (sel_kind == K_RESET);
    assign evs[EV_FLAG] = |ev;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            status_ff <= RST_EV;
        end else if (rd_i && addr_i == OFF_STATUS) begin
            status_ff <= evs;
        end else begin
            status_ff <= status_ff | evs;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= RST_EV;
        end else if (wr_i && addr_i == OFF_MASK) begin
            mask_ff <= wdata_i[EV_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_ff & mask_ff);
        end
    end

    // ****************************************
    // register read port
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else if (!rd_i) begin
            rdata_o <= '0;
        end else if (addr_i == OFF_FLAGS) begin
            rdata_o <= {8'h00, flags_ff};
        end else if (addr_i == OFF_STATUS) begin
            rdata_o <= {11'h000, status_ff};
        end else if (addr_i == OFF_MASK) begin
            rdata_o <= {11'h000, mask_ff};
        end else if (addr_i == OFF_LEVEL) begin
            rdata_o <= {10'h000, trap_lvl_ff, cpu_level_o};
        end else if (src_hit(addr_i)) begin
            rdata_o <= {8'h00, ctrl_ff[src_idx(addr_i)]};
        end else begin
            rdata_o <= '0;
        end
    end
endmodule : trap_and_vector_dispatch

// ### verilog/trap_pkg.sv
// constants, register map and vector helpers for trap and vector dispatch
// How it works
// - all resets branch to vector 0, number 0
// - class A traps use their own vectors
// - class B traps share vector 28h
// - five class B causes, each own flag
// - every hardware trap sets its flag bit
// - hardware traps are non-maskable, branch to vector
// - new trap preempts unless an equal or higher trap is running
// - trap service blocks interrupts and transfer requests
// - software trap 00h-7Fh, keeps current priority
// - per-source control: request, enable, sixteen priorities
// - only strictly higher priority interrupts a service
// - each source has its own vector
package trap_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 16;
    localparam int NUM_SRC = 8;
    localparam int IDX_W   = 3;
    localparam int LVL_W   = 4;
    localparam int TLVL_W  = 2;
    localparam int FLAG_W  = 8;
    localparam int EV_W    = 5;
    localparam int CTRL_W  = 8;
    localparam int VEC_W   = 24;
    localparam int TN_W    = 8;
    localparam int STACK_D = 4;
    localparam int SP_W    = 3;
    localparam int SPI_W   = 2;

    // ****************************************
    // trap numbers and vectors
    // ****************************************
    localparam logic [TN_W-1:0]  TN_RESET    = 8'h00;
    localparam logic [TN_W-1:0]  TN_NMI      = 8'h02;
    localparam logic [TN_W-1:0]  TN_STACK_OVERRUN_FLAG    = 8'h04;
    localparam logic [TN_W-1:0]  TN_STACK_UNDERRUN_FLAG    = 8'h06;
    localparam logic [TN_W-1:0]  TN_CLASS_B  = 8'h0A;
    localparam logic [TN_W-1:0]  TN_SRC_BASE = 8'h10;
    localparam logic [VEC_W-1:0] RESET_VECTOR          = 24'h000000;
    localparam logic [VEC_W-1:0] NONMASKABLE_VECTOR    = 24'h000008;
    localparam logic [VEC_W-1:0] STACK_OVERRUN_VECTOR  = 24'h000010;
    localparam logic [VEC_W-1:0] STACK_UNDERRUN_VECTOR = 24'h000018;
    localparam logic [VEC_W-1:0] CLASS_B_SHARED_VECTOR = 24'h000028;

    // ****************************************
    // trap priority levels
    // ****************************************
    localparam logic [TLVL_W-1:0] TPRI_NONE = 2'h0;
    localparam logic [TLVL_W-1:0] TPRI_B    = 2'h1;
    localparam logic [TLVL_W-1:0] TPRI_A    = 2'h2;

    // ****************************************
    // exception flag register bits
    // ****************************************
    localparam int F_NMI   = 0;
    localparam int F_STACK_OVERRUN_FLAG = 1;
    localparam int F_STACK_UNDERRUN_FLAG = 2;
    localparam int F_UNK   = 3;
    localparam int F_PROT  = 4;
    localparam int F_MIS   = 5;
    localparam int F_FETCH = 6;
    localparam int F_BUS   = 7;

    // ****************************************
    // status event bits and control fields
    // ****************************************
    localparam int EV_TRAP = 0;
    localparam int EV_INT  = 1;
    localparam int EV_SW   = 2;
    localparam int EV_RST  = 3;
    localparam int EV_FLAG = 4;
    localparam int C_EN    = 6;
    localparam int C_REQ   = 7;

    // ****************************************
    // register offsets and reset values
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_FLAGS    = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_LEVEL    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_SRC_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SRC_END  = 8'h30;
    localparam logic [FLAG_W-1:0] RST_FLAGS    = 8'h00;
    localparam logic [EV_W-1:0]   RST_EV       = 5'h00;
    localparam logic [CTRL_W-1:0] RST_CTRL     = 8'h00;
    localparam logic [LVL_W-1:0]  RST_LVL      = 4'h0;

    typedef enum logic [2:0] {K_NONE, K_RESET, K_TRAP_A, K_TRAP_B, K_SW, K_INT} kind_t;
    typedef enum logic {ST_IDLE, ST_OFFER} state_t;

    function automatic logic [VEC_W-1:0] vec_of(input logic [TN_W-1:0] tn);
        vec_of = {14'h0000, tn, 2'h0};
    endfunction : vec_of
endpackage : trap_pkg

// ### verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      lvl_o
);
    logic s1_ff;
    logic s2_ff;
    logic s3_ff;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // level moves only once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_o <= RST_VAL;
        end else if (s2_ff == s3_ff) begin
            lvl_o <= s3_ff;
        end
    end
endmodule : pin_sync

// ### verilog/irq_arbiter.sv
// picks the highest priority active interrupt source
`timescale 1ns/1ps
module irq_arbiter
    import trap_pkg::*;
(
    input  wire logic [NUM_SRC-1:0]       act_i,
    input  wire logic [NUM_SRC*LVL_W-1:0] prio_i,
    output logic                          win_vld_o,
    output logic [IDX_W-1:0]              win_idx_o,
    output logic [LVL_W-1:0]              win_prio_o
);
    // ties go to the lowest index
    always_comb begin
        win_vld_o  = 1'b0;
        win_idx_o  = '0;
        win_prio_o = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (act_i[i] && (!win_vld_o || prio_i[i*LVL_W +: LVL_W] > win_prio_o)) begin
                win_vld_o  = 1'b1;
                win_idx_o  = IDX_W'(i);
                win_prio_o = prio_i[i*LVL_W +: LVL_W];
            end
        end
    end
endmodule : irq_arbiter

// ### tb/trap_and_vector_dispatch_monitor.sv
// port checker of the dispatch block
`timescale 1ns/1ps
module trap_monitor
    import trap_pkg::*;
(
    input logic             clk_i,
    input logic             nrst_i,
    input logic             sw_reset_i,
    input logic             stack_overrun_i,
    input logic             bad_bus_i,
    input logic             pec_req_i,
    input logic             pec_grant_o,
    input logic             vector_valid_o,
    input logic [VEC_W-1:0] vector_addr_o,
    input logic [TN_W-1:0]  trap_num_o,
    input logic             vector_ack_i,
    input logic             in_trap_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_rst; $rose(nrst_i) |-> !vector_valid_o ##[1:7] vector_valid_o && !trap_num_o; endproperty
    a_rst: assert property (p_rst) else $error("reset vector");
    property p_swr; sw_reset_i && !vector_valid_o |-> ##[2:40] vector_valid_o && !trap_num_o; endproperty
    a_swr: assert property (p_swr) else $error("soft reset");
    property p_ovr; stack_overrun_i && !in_trap_o |-> ##[1:40] vector_addr_o == 24'h000010; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun vector");
    property p_clb; bad_bus_i && !in_trap_o |-> ##[1:40] vector_addr_o == 24'h000028; endproperty
    a_clb: assert property (p_clb) else $error("class b vector");
    property p_num; vector_valid_o |-> vector_addr_o == {14'h0, trap_num_o, 2'h0}; endproperty
    a_num: assert property (p_num) else $error("vector not num x4");
    property p_rng; vector_valid_o |-> !trap_num_o[7]; endproperty
    a_rng: assert property (p_rng) else $error("number range");
    property p_hld; vector_valid_o && !vector_ack_i |=> vector_valid_o && $stable(trap_num_o); endproperty
    a_hld: assert property (p_hld) else $error("offer changed");
    property p_pec; pec_grant_o |-> $past(pec_req_i) && !in_trap_o; endproperty
    a_pec: assert property (p_pec) else $error("grant in trap");
endmodule : trap_monitor
bind trap_and_vector_dispatch trap_monitor mon_u (.*);

// ### tb/core_model.sv
// processor core model: takes vectors, returns from services
`timescale 1ns/1ps
module core_model
    import trap_pkg::*;
(
    input  logic            clk_i,
    input  logic            nrst_i,
    input  logic            hold_i,
    input  logic            vector_valid_i,
    input  logic [TN_W-1:0] trap_num_i,
    output logic            vector_ack_o,
    output logic            service_done_o
);
    logic [TN_W-1:0] log_q[$];
    int              owed = 0, cnt = 0, dly = 0;
    always @(posedge clk_i or negedge nrst_i) begin
        vector_ack_o <= 1'b0;
        service_done_o <= 1'b0;
        if (!nrst_i) begin
            owed = 0;
            cnt = 0;
        end else if (vector_valid_i && !vector_ack_o) begin
            if (cnt == dly) begin
                vector_ack_o <= 1'b1;
                log_q.push_back(trap_num_i);
                owed = (trap_num_i == 8'h00) ? 0 : owed + 1;
                cnt = 0;
                dly = 3 - dly;
            end else begin
                cnt++;
            end
        end else if (owed > 0 && !hold_i && !vector_valid_i && !service_done_o) begin
            service_done_o <= 1'b1;
            owed--;
        end
    end
endmodule : core_model

// ### tb/trap_and_vector_dispatch_bench.sv
// self-checking bench of the dispatch block
`timescale 1ns/1ps
module trap_and_vector_dispatch_bench
    import trap_pkg::*;
;
    logic               clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, hold = 1'b0;
    logic               nmi_n_i = 1'b1, pec_req_i = 1'b0, irq_o, pec_grant_o, vld, ack, done;
    logic [ADDR_W-1:0]  addr_i = 8'h00;
    logic [DATA_W-1:0]  wdata_i = 16'h0000, rdata_o;
    logic [9:0]         ev = 10'h000;
    logic [6:0]         n = 7'h00;
    logic [NUM_SRC-1:0] src_ev = 8'h00;
    logic [LVL_W-1:0]   cpu_level_o;
    logic [TN_W-1:0]    num_v, exp_q[$];
    int                 failures = 0, comparisons = 0, cyc = 0, v, seed = 32'hF24697D0;
    trap_and_vector_dispatch dut_u (.*, .sw_reset_i(ev[0]), .wdt_overflow_i(ev[1]),
        .stack_overrun_i(ev[2]), .stack_underrun_i(ev[3]), .unknown_opcode_i(ev[4]),
        .protected_fault_i(ev[5]), .misaligned_operand_i(ev[6]), .bad_fetch_i(ev[7]),
        .bad_bus_i(ev[8]), .sw_trap_i(ev[9]), .sw_trap_num_i(n), .src_event_i(src_ev),
        .vector_valid_o(vld), .vector_addr_o(), .trap_num_o(num_v), .vector_ack_i(ack),
        .service_done_i(done), .in_trap_o());
    core_model core_u (.*, .hold_i(hold), .vector_valid_i(vld), .trap_num_i(num_v),
        .vector_ack_o(ack), .service_done_o(done));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [DATA_W-1:0] e, g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    task wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i) wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task rdc(input logic [7:0] a, input logic [15:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i) rd_i <= 1'b0;
        @(negedge clk_i) chk("register", e, rdata_o);
        @(posedge clk_i);
    endtask : rdc
    task pulse(input int b);
        ev[b] <= 1'b1;
        @(posedge clk_i) ev[b] <= 1'b0;
        @(posedge clk_i);
    endtask : pulse
    task settle;
        for (int i = 0; i < 300 && (core_u.log_q.size() < exp_q.size()
             || (!hold && core_u.owed != 0)); i++) @(posedge clk_i);
        chk("count", 16'(exp_q.size()), 16'(core_u.log_q.size()));
        while (exp_q.size() > 0 && core_u.log_q.size() > 0)
            chk("number", 16'(exp_q.pop_front()), 16'(core_u.log_q.pop_front()));
    endtask : settle
    initial begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        exp_q.push_back(TN_RESET);
        settle();
        rdc(OFF_FLAGS, 16'h0000);
        nmi_n_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        nmi_n_i <= 1'b1;
        exp_q.push_back(TN_NMI);
        settle();
        for (int b = 2; b < 9; b++) begin
            pulse(b);
            exp_q.push_back(b == 2 ? TN_STACK_OVERRUN_FLAG : b == 3 ? TN_STACK_UNDERRUN_FLAG : TN_CLASS_B);
            settle();
        end
        rdc(OFF_FLAGS, 16'hFF);
        wr(OFF_FLAGS, 16'hFF);
        rdc(OFF_FLAGS, 16'h0000);
        hold <= 1'b1;
        pec_req_i <= 1'b1;
        pulse(4);
        pulse(2);
        pulse(3);
        exp_q = '{TN_CLASS_B, TN_STACK_OVERRUN_FLAG};
        settle();
        repeat (10) @(posedge clk_i);
        @(negedge clk_i) chk("offer", 16'h0, 16'(vld));
        chk("grant", 16'h0, 16'(pec_grant_o));
        @(posedge clk_i) hold <= 1'b0;
        exp_q.push_back(TN_STACK_UNDERRUN_FLAG);
        settle();
        repeat (3) @(negedge clk_i);
        chk("grant", 16'h1, 16'(pec_grant_o));
        @(posedge clk_i) pec_req_i <= 1'b0;
        rdc(OFF_STATUS, 16'h19);
        wr(OFF_MASK, 16'h1F);
        hold <= 1'b1;
        wr(OFF_SRC_BASE, 16'h45);
        src_ev <= 8'h01;
        @(posedge clk_i) src_ev <= 8'h00;
        exp_q.push_back(TN_SRC_BASE);
        settle();
        rdc(OFF_LEVEL, 16'h5);
        chk("cpu level", 16'h5, 16'(cpu_level_o));
        wr(OFF_SRC_BASE + 8'h04, 16'hC5);
        wr(OFF_SRC_BASE + 8'h08, 16'hC9);
        exp_q.push_back(TN_SRC_BASE + 8'h02);
        settle();
        @(negedge clk_i) chk("irq", 16'h1, 16'(irq_o));
        @(posedge clk_i) rdc(OFF_STATUS, 16'h2);
        @(negedge clk_i) chk("irq", 16'h0, 16'(irq_o));
        @(posedge clk_i) hold <= 1'b0;
        exp_q.push_back(TN_SRC_BASE + 8'h01);
        settle();
        rdc(OFF_SRC_BASE, 16'h45);
        wr(OFF_LEVEL, 16'hFFFF);
        rdc(OFF_LEVEL, 16'h0);
        rdc(8'h40, 16'h0);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 127 : 1 + {$random(seed)} % 127;
            n <= 7'(v);
            pulse(9);
            exp_q.push_back(8'(v));
            settle();
        end
        pulse(7);
        pulse(1);
        exp_q = '{TN_CLASS_B, TN_RESET};
        settle();
        pulse(0);
        exp_q.push_back(TN_RESET);
        settle();
        rdc(OFF_FLAGS, 16'h4E);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        exp_q.push_back(TN_RESET);
        settle();
        rdc(OFF_FLAGS, 16'h0000);
        complete_run();
    end
endmodule : trap_and_vector_dispatch_bench
